// ==== common/sfc_pkg.sv ====
package sfc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] CFG_ADDR = 32'hfffffe00;
  localparam logic [31:0] STAT_ADDR = 32'hfffffe10;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SYNC_POS = 7;
  localparam int CHAR_POS = 6;
  localparam int PAR_ON_POS = 5;
  localparam int PAR_ODD_POS = 4;
  localparam int STOP_POS = 3;
  localparam int MP_POS = 2;
  localparam int PRE_HI_POS = 1;
  localparam int PRE_LO_POS = 0;
  // ------------------------------------------------------------
  // Bus answers and counts
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [3:0] FRAME_START_BITS = 4'h1;
  localparam logic [3:0] DATA8_BITS = 4'h8;
  localparam logic [3:0] DATA7_BITS = 4'h7;
  typedef enum logic [1:0] {
    PRE_DIV4 = 2'b00,
    PRE_DIV16 = 2'b01,
    PRE_DIV64 = 2'b10,
    PRE_DIV256 = 2'b11
  } sfc_pre_type;
  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } sfc_rd_type;
  // Last count of the prescaler for each setting
  function automatic logic [7:0] sfc_div_last(input logic [1:0] sel);
    case (sel)
      PRE_DIV4: sfc_div_last = 8'h03;
      PRE_DIV16: sfc_div_last = 8'h0f;
      PRE_DIV64: sfc_div_last = 8'h3f;
      default: sfc_div_last = 8'hff;
    endcase
  endfunction
endpackage

// ==== common/sfc_fmt_if.sv ====
`timescale 1ns/10ps
interface sfc_fmt_if;
  logic seven_bit;
  logic parity_on;
  logic parity_odd;
  logic [1:0] prescale_sel;
  logic tick;
  logic [7:0] pre_count;
  modport cfg (
    output seven_bit, parity_on, parity_odd, prescale_sel,
    input tick, pre_count
  );
  modport pre (input prescale_sel, output tick, pre_count);
  modport par (input seven_bit, parity_on, parity_odd);
endinterface

// ==== verilog/sfc_prescale.sv ====
`timescale 1ns/10ps
module sfc_prescale (
  input wire logic aclk,
  input wire logic aresetn,
  sfc_fmt_if.pre fmt
);
  import sfc_pkg::*;
  logic [7:0] count;
  logic [1:0] last_sel;
  wire logic [7:0] div_last = sfc_div_last(fmt.prescale_sel);
  wire logic sel_changed = last_sel != fmt.prescale_sel;
  wire logic wrap = count >= div_last;
  wire logic [7:0] next_count =
    (sel_changed || wrap) ? PRE_RESET : count + 8'h01;
  // ------------------------------------------------------------
  // Divide phi by 4, 16, 64 or 256
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= PRE_RESET;
      last_sel <= PRE_DIV4;
      fmt.tick <= 1'b0;
    end else begin
      count <= next_count;
      last_sel <= fmt.prescale_sel;
      fmt.tick <= wrap && !sel_changed;
    end
  end
  assign fmt.pre_count = count;
endmodule

// ==== verilog/sfc_parity.sv ====
`timescale 1ns/10ps
module sfc_parity (
  input wire logic aclk,
  input wire logic aresetn,
  sfc_fmt_if.par fmt,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  output logic tx_parity_bit,
  output logic rx_parity_err
);
  import sfc_pkg::*;
  // Seven-bit characters leave bit 7 out of the sum
  wire logic [7:0] char_mask = fmt.seven_bit ? 8'h7f : 8'hff;
  wire logic tx_sum = ^(tx_data & char_mask) ^ fmt.parity_odd;
  wire logic rx_sum = ^(rx_data & char_mask) ^ fmt.parity_odd;
  // ------------------------------------------------------------
  // Generate and check parity
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_parity_bit <= 1'b0;
      rx_parity_err <= 1'b0;
    end else begin
      tx_parity_bit <= fmt.parity_on & tx_sum;
      rx_parity_err <= fmt.parity_on & (rx_sum != rx_parity);
    end
  end
endmodule

// ==== verilog/sfc_top.sv ====
`timescale 1ns/10ps
module sfc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axil_awaddr,
  input wire logic [2:0] s_axil_awprot,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [31:0] s_axil_araddr,
  input wire logic [2:0] s_axil_arprot,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  output logic sync_mode,
  output logic char_len_sel,
  output logic parity_on,
  output logic parity_odd,
  output logic two_stop,
  output logic multiproc_fmt_sel,
  output logic prescale_sel_hi,
  output logic prescale_sel_lo,
  output logic [3:0] frame_bits,
  output logic baud_tick,
  output logic tx_parity_bit,
  output logic rx_parity_err
);
  import sfc_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] serial_frame_config;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  sfc_rd_type rd_state;
  sfc_fmt_if fmt ();

  // ------------------------------------------------------------
  // Write channel decode
  // ------------------------------------------------------------
  wire logic aw_fire = s_axil_awvalid && s_axil_awready;
  wire logic w_fire = s_axil_wvalid && s_axil_wready;
  wire logic have_aw = aw_held || aw_fire;
  wire logic have_w = w_held || w_fire;
  wire logic do_write = have_aw && have_w && !s_axil_bvalid;
  wire logic [31:0] wr_addr = aw_held ? aw_addr : s_axil_awaddr;
  wire logic [31:0] wr_data = w_held ? w_data : s_axil_wdata;
  wire logic [3:0] wr_strb = w_held ? w_strb : s_axil_wstrb;
  wire logic wr_cfg = wr_addr == CFG_ADDR;
  wire logic wr_stat = wr_addr == STAT_ADDR;
  wire logic wr_hit = wr_cfg || wr_stat;
  wire logic cfg_load = do_write && wr_cfg && wr_strb[0];
  wire logic [1:0] next_bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
  wire logic [7:0] next_cfg =
    cfg_load ? wr_data[7:0] : serial_frame_config;

  assign s_axil_awready = !aw_held && !s_axil_bvalid;
  assign s_axil_wready = !w_held && !s_axil_bvalid;

  // ------------------------------------------------------------
  // Read channel decode
  // ------------------------------------------------------------
  wire logic ar_fire = s_axil_arvalid && s_axil_arready;
  wire logic rd_cfg = s_axil_araddr == CFG_ADDR;
  wire logic rd_stat = s_axil_araddr == STAT_ADDR;
  wire logic [31:0] stat_word = {16'h0000, fmt.pre_count, 4'h0, frame_bits};
  wire logic [31:0] next_rdata =
    rd_cfg ? {24'h000000, serial_frame_config} :
    rd_stat ? stat_word : 32'h00000000;
  wire logic [1:0] next_rresp =
    (rd_cfg || rd_stat) ? RESP_OKAY : RESP_DECERR;

  assign s_axil_arready = rd_state == RD_IDLE;
  assign s_axil_rvalid = rd_state == RD_RESP;

  // ------------------------------------------------------------
  // Write address and data capture
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      aw_addr <= s_axil_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (w_fire) begin
      w_held <= 1'b1;
      w_data <= s_axil_wdata;
      w_strb <= s_axil_wstrb;
    end
  end

  // ------------------------------------------------------------
  // Write response
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= next_bresp;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Frame mode register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_frame_config <= CFG_RESET;
    end else begin
      serial_frame_config <= next_cfg;
    end
  end

  // ------------------------------------------------------------
  // Read response
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (ar_fire) begin
            rd_state <= RD_RESP;
            s_axil_rdata <= next_rdata;
            s_axil_rresp <= next_rresp;
          end
        end
        RD_RESP: begin
          if (s_axil_rready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Field outputs
  // ------------------------------------------------------------
  assign sync_mode = serial_frame_config[SYNC_POS];
  assign char_len_sel = serial_frame_config[CHAR_POS];
  assign parity_on = serial_frame_config[PAR_ON_POS];
  assign parity_odd = serial_frame_config[PAR_ODD_POS];
  assign two_stop = serial_frame_config[STOP_POS];
  assign multiproc_fmt_sel = serial_frame_config[MP_POS];
  assign prescale_sel_hi = serial_frame_config[PRE_HI_POS];
  assign prescale_sel_lo = serial_frame_config[PRE_LO_POS];

  assign fmt.seven_bit = char_len_sel;
  assign fmt.parity_on = parity_on;
  assign fmt.parity_odd = parity_odd;
  assign fmt.prescale_sel = {prescale_sel_hi, prescale_sel_lo};
  assign baud_tick = fmt.tick;

  // ------------------------------------------------------------
  // Frame length in bit times
  // ------------------------------------------------------------
  wire logic [3:0] data_bits =
    char_len_sel ? DATA7_BITS : DATA8_BITS;
  wire logic [3:0] par_bits = {3'h0, parity_on};
  wire logic [3:0] stop_bits = two_stop ? 4'h2 : 4'h1;
  wire logic [3:0] mp_bits = {3'h0, multiproc_fmt_sel};
  wire logic [3:0] async_bits =
    FRAME_START_BITS + data_bits + par_bits + stop_bits + mp_bits;
  // Clocked mode moves bare data bits only
  wire logic [3:0] next_frame_bits =
    sync_mode ? data_bits : async_bits;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_bits <= 4'h0;
    end else begin
      frame_bits <= next_frame_bits;
    end
  end

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  sfc_prescale u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .fmt(fmt.pre)
  );

  sfc_parity u_parity (
    .aclk(aclk),
    .aresetn(aresetn),
    .fmt(fmt.par),
    .tx_data(tx_data),
    .rx_data(rx_data),
    .rx_parity(rx_parity),
    .tx_parity_bit(tx_parity_bit),
    .rx_parity_err(rx_parity_err)
  );
endmodule

// ==== tb/sfc_sva.sv ====
`timescale 1ns/10ps
module sfc_sva
  import sfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  input wire logic sync_mode,
  input wire logic char_len_sel,
  input wire logic parity_on,
  input wire logic parity_odd,
  input wire logic two_stop,
  input wire logic multiproc_fmt_sel,
  input wire logic prescale_sel_hi,
  input wire logic prescale_sel_lo,
  input wire logic [3:0] frame_bits,
  input wire logic baud_tick,
  input wire logic tx_parity_bit,
  input wire logic rx_parity_err
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  wire logic [7:0] flds = {sync_mode, char_len_sel, parity_on,
    parity_odd, two_stop, multiproc_fmt_sel, prescale_sel_hi,
    prescale_sel_lo};
  wire logic [1:0] sel = {prescale_sel_hi, prescale_sel_lo};
  wire logic [7:0] mask = {!char_len_sel, 7'h7f};
  wire logic [3:0] dbits = char_len_sel ? 4'h7 : 4'h8;
  wire logic [3:0] exp_bits = sync_mode ? dbits : 4'h1 + dbits +
    {3'h0, parity_on} + (two_stop ? 4'h2 : 4'h1) +
    {3'h0, multiproc_fmt_sel};
  logic [8:0] gap;
  logic clean;
  logic [1:0] last_sel;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 9'h0;
      clean <= 1'b0;
      last_sel <= 2'h0;
    end else begin
      last_sel <= sel;
      gap <= baud_tick ? 9'h1 : gap + 9'h1;
      clean <= (sel != last_sel) ? 1'b0 : (baud_tick | clean);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence s_rd;
    s_axil_arvalid && s_axil_arready;
  endsequence
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_field_map: assert property (s_wr ##0 (s_axil_awaddr == CFG_ADDR &&
    s_axil_wstrb[0]) |=> flds == $past(s_axil_wdata[7:0]))
    else $error("field outputs differ from written byte");
  a_strobe_skip: assert property (s_wr ##0 !s_axil_wstrb[0]
    |=> $stable(flds)) else $error("write without strobe changed fields");
  a_write_resp: assert property (s_wr |=> s_axil_bvalid && s_axil_bresp ==
    (($past(s_axil_awaddr) == CFG_ADDR || $past(s_axil_awaddr) ==
    STAT_ADDR) ? RESP_OKAY : RESP_DECERR)) else $error("bad write answer");
  a_resp_hold: assert property (s_axil_bvalid && !s_axil_bready |=>
    s_axil_bvalid && $stable(s_axil_bresp)) else $error("bvalid dropped");
  a_read_back: assert property (s_rd ##0 s_axil_araddr == CFG_ADDR |=>
    s_axil_rvalid && s_axil_rdata == {24'h0, flds})
    else $error("config read mismatch");
  a_read_unmap: assert property (s_rd ##0 (s_axil_araddr != CFG_ADDR &&
    s_axil_araddr != STAT_ADDR) |=> s_axil_rvalid && s_axil_rdata == 0 &&
    s_axil_rresp == RESP_DECERR) else $error("unmapped read answer");
  a_parity_off: assert property (!$past(parity_on) |->
    !tx_parity_bit && !rx_parity_err) else $error("parity active while off");
  a_tx_parity: assert property ($past(parity_on) |-> tx_parity_bit ==
    (^($past(tx_data) & $past(mask)) ^ $past(parity_odd)))
    else $error("sent parity bit wrong");
  a_rx_check: assert property ($past(parity_on) |-> rx_parity_err ==
    (^($past(rx_data) & $past(mask)) ^ $past(rx_parity) ^ $past(parity_odd)))
    else $error("receive parity check wrong");
  a_frame_count: assert property ($past(aresetn) |->
    frame_bits == $past(exp_bits))
    else $error("frame bit count wrong");
  a_tick_period: assert property (baud_tick && clean |->
    gap == (9'h4 << {sel, 1'b0})) else $error("prescaler period wrong");
endmodule

// ==== tb/sfc_remote.sv ====
`timescale 1ns/10ps
module sfc_remote (
  input wire logic aclk,
  input wire logic [7:0] chr,
  input wire logic odd,
  input wire logic seven,
  input wire logic bad,
  output logic [7:0] rx_data,
  output logic rx_parity
);
  wire logic [7:0] mask = {!seven, 7'h7f};
  always_ff @(posedge aclk) begin
    rx_data <= chr & mask;
    rx_parity <= ^(chr & mask) ^ odd ^ bad;
  end
endmodule

// ==== tb/test_sfc_top.sv ====
`timescale 1ns/10ps
module test_sfc_top;
  import sfc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] s_axil_awaddr = '0, s_axil_wdata = '0, s_axil_araddr = '0;
  logic [2:0] s_axil_awprot = '0, s_axil_arprot = '0;
  logic [3:0] s_axil_wstrb = '0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
  logic s_axil_rvalid, baud_tick, tx_parity_bit, rx_parity_err;
  logic [1:0] s_axil_bresp, s_axil_rresp, r;
  logic [31:0] s_axil_rdata, d;
  logic [7:0] tx_data = '0, chr = '0, rx_data, c;
  logic rx_parity, odd = 0, seven = 0, bad = 0, p;
  logic sync_mode, char_len_sel, parity_on, parity_odd, two_stop;
  logic multiproc_fmt_sel, prescale_sel_hi, prescale_sel_lo;
  logic [3:0] frame_bits;
  int mismatches = 0, num_checks = 0, g;
  wire logic [7:0] flds = {sync_mode, char_len_sel, parity_on,
    parity_odd, two_stop, multiproc_fmt_sel, prescale_sel_hi,
    prescale_sel_lo};
  sfc_top sfc_top_i (.*);
  sfc_remote sfc_remote_i (.aclk(aclk), .chr(chr), .odd(odd),
    .seven(seven), .bad(bad), .rx_data(rx_data), .rx_parity(rx_parity));
  initial forever #20 aclk = ~aclk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task end_sim;
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, e, input string n);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [3:0] fb(input logic [7:0] v);
    logic [3:0] n;
    n = v[6] ? 4'h7 : 4'h8;
    fb = v[7] ? n : 4'h1 + n + {3'h0, v[5]} + (v[3] ? 4'h2 : 4'h1) +
      {3'h0, v[2]};
  endfunction
  task automatic wr(input logic [31:0] a, v, input logic [3:0] s);
    logic ta, tw, bv;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= v;
    s_axil_wstrb <= s;
    s_axil_awvalid <= 1;
    s_axil_wvalid <= 1;
    s_axil_bready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axil_awvalid & s_axil_awready;
      tw = s_axil_wvalid & s_axil_wready;
      bv = (s_axil_bvalid === 1'b1);
      r = s_axil_bresp;
      @(posedge aclk);
      if (ta) s_axil_awvalid <= 0;
      if (tw) s_axil_wvalid <= 0;
    end while (!bv);
    s_axil_bready <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    logic ta, bv;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1;
    s_axil_rready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axil_arvalid & s_axil_arready;
      bv = (s_axil_rvalid === 1'b1);
      d = s_axil_rdata;
      r = s_axil_rresp;
      @(posedge aclk);
      if (ta) s_axil_arvalid <= 0;
    end while (!bv);
    s_axil_rready <= 0;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(CFG_ADDR);
    chk(d, 32'h0, "cfg reset");
    for (int i = 0; i < 9; i++) begin
      c = (i == 8) ? 8'hff : 8'h01 << i;
      wr(CFG_ADDR, {24'h0, c}, 4'h1);
      rd(CFG_ADDR);
      chk(d, {24'h0, c}, "cfg read");
      chk(flds, c, "fields");
      chk(frame_bits, fb(c), "frame bits");
    end
    wr(CFG_ADDR, 32'h5a, 4'he);
    rd(CFG_ADDR);
    chk(d, 32'hff, "no strobe");
    wr(CFG_ADDR + 32'h4, 32'h0, 4'hf);
    chk(r, RESP_DECERR, "unmapped wr");
    rd(CFG_ADDR + 32'h4);
    chk(d, 32'h0, "unmapped rd data");
    chk(r, RESP_DECERR, "unmapped rd resp");
    rd(STAT_ADDR);
    chk(d[3:0], fb(8'hff), "status bits");
    for (int s = 0; s < 4; s++) begin
      wr(CFG_ADDR, s, 4'h1);
      repeat (2) begin
        g = 0;
        do begin
          @(negedge aclk);
          g++;
        end while (baud_tick !== 1'b1 && g < 600);
      end
      chk(g, 4 << (2 * s), "tick gap");
    end
    for (int k = 0; k < 5; k++) begin
      c = (k == 4) ? 8'h0 : {1'b0, k[0], 1'b1, k[1], 4'h0};
      wr(CFG_ADDR, {24'h0, c}, 4'h1); // Format set before data
      for (int b = 0; b < 2; b++) begin
        @(posedge aclk);
        tx_data <= 8'hb5;
        chr <= 8'hb5;
        seven <= k[0];
        odd <= k[1];
        bad <= b[0];
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        p = (k < 4) & (^(8'hb5 & {!k[0], 7'h7f}) ^ k[1]);
        chk(tx_parity_bit, p, "tx parity");
        chk(rx_parity_err, (k < 4) & b[0], "rx parity");
      end
    end
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim;
  end
endmodule
bind sfc_top sfc_sva sfc_sva_i (.*);
